// ===== hw/iocg_defines.vh
// Constants shared by the I/O cell gearing design.
// Assumes inclusion by bare name from hw/.
`ifndef IOCG_DEFINES_VH
`define IOCG_DEFINES_VH
// ****************************************
// Gearing mode codes
// ****************************************
`define IOCG_GEAR_ONE   3'h0
`define IOCG_GEAR_TWO   3'h1
`define IOCG_GEAR_FOUR  3'h2
`define IOCG_GEAR_FIVE  3'h3
`define IOCG_GEAR_SEVEN 3'h4
// ****************************************
// Word widths per mode
// ****************************************
`define IOCG_BITS_ONE   4'h2
`define IOCG_BITS_TWO   4'h4
`define IOCG_BITS_FOUR  4'h8
`define IOCG_BITS_FIVE  4'ha
`define IOCG_BITS_SEVEN 4'h7
`define IOCG_WORD_W     10
`define IOCG_WORD_MAX   4'ha
// ****************************************
// Input FIFO and edge monitor
// ****************************************
`define IOCG_FIFO_DEPTH 8
`define IOCG_FIFO_AW    3
`define IOCG_FIFO_W     1
`define IOCG_EYE_W      8
`define IOCG_SYNC_W     6
`endif

// ===== hw/iocg_sync.v
// Two-stage level synchroniser for a bundle of inputs.
// Assumes every input is asynchronous to clk.
`timescale 1ns/1ps
module iocg_sync #(
    parameter WIDTH = 6
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] meta;

    // ****************************************
    // Double flop
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {WIDTH{1'b0}};
            dout <= {WIDTH{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // iocg_sync

// ===== hw/iocg_fifo.v
// Input FIFO with valid/ready on both sides.
// Assumes one clock; pointers are exported to the group.
`timescale 1ns/1ps
module iocg_fifo #(
    parameter WIDTH = 1,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             clk,
    input  wire             rstn,
    input  wire             clear,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData,
    output wire [AW-1:0]    writePointer,
    output wire [AW-1:0]    readPointer
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr;
    reg [AW:0]      rdPtr;
    wire            doWrite;
    wire            doRead;

    assign outValid     = (wrPtr != rdPtr);
    assign inReady      = (wrPtr[AW-1:0] != rdPtr[AW-1:0]) ||
                          (wrPtr[AW] == rdPtr[AW]);
    assign doWrite      = inValid && inReady;
    assign doRead       = outValid && outReady;
    assign outData      = mem[rdPtr[AW-1:0]];
    assign writePointer = wrPtr[AW-1:0];
    assign readPointer  = rdPtr[AW-1:0];

    // ****************************************
    // Storage
    // ****************************************
    always @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr[AW-1:0]] <= inData;
        end
    end

    // ****************************************
    // Pointers
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr <= {(AW+1){1'b0}};
            rdPtr <= {(AW+1){1'b0}};
        end else if (clear) begin
            wrPtr <= {(AW+1){1'b0}};
            rdPtr <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
        end
    end
endmodule // iocg_fifo

// ===== hw/iocg_io_cell.v
// One I/O cell: geared input, output and tristate paths.
// Assumes clk far faster than the sampled link clocks.
//
// Functional notes
// - Gearing and eye monitor only on bottom
// - First stage samples both fast edges
// - Second stage slips on align request
// - Third stage transfers on slow clock
// - Input gears x1, x2, x4, x5
// - Seven-to-one only on linked cell pair
// - Word width 2, 4, 7, 8, 10
// - Input FIFO ahead of the gearing
// - FIFO written on strobe, read on edge
// - One pointer unit per strobe group
// - Bottom outputs serialise all gears
// - Other edges output single rate only
// - Strobe and data from write clocks
// - Single-rate enable through one flop
// - Two-bit enable on edge and slow clock
// - Tristate path has own reset
// - Three-bit FIFO pointers exported
`timescale 1ns/1ps
`include "iocg_defines.vh"
module iocg_io_cell #(
    parameter BOTTOM_EDGE = 1
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        fastEdgeClock,
    input  wire        sysClock,
    input  wire        serialIn,
    input  wire        strobeClock,
    input  wire        writeStrobeClock,
    input  wire        writeDataClockQ,
    input  wire        inputBlockReset,
    input  wire        outputBlockReset,
    input  wire        tristateBlockReset,
    input  wire [2:0]  gearMode,
    input  wire        memReadMode,
    input  wire        memWriteMode,
    input  wire        sdrOutMode,
    input  wire        ioCellPairLinked,
    input  wire        wordAlignRequest,
    input  wire [9:0]  parWordIn,
    input  wire        sdrDataIn,
    input  wire        outputEnableIn,
    input  wire [1:0]  outputEnableInDdr,
    input  wire        tristateDdrGear,
    output reg  [9:0]  parWordOut,
    output reg         parWordValid,
    output wire [2:0]  fifoReadPointer,
    output wire [2:0]  fifoWritePointer,
    output wire        fifoInReady,
    output reg         fifoOverflow,
    output reg         serialOut,
    output reg         strobeOut,
    output reg         outputEnableOut,
    output reg  [7:0]  eyeCentre
);
    // ****************************************
    // Functions
    // ****************************************
    function [2:0] gearSel;
        input [2:0] mode;
        input       pair;
        begin
            gearSel = mode;
            if (BOTTOM_EDGE == 0 || mode > `IOCG_GEAR_SEVEN) begin
                gearSel = `IOCG_GEAR_ONE;
            end else if (mode == `IOCG_GEAR_SEVEN && !pair) begin
                gearSel = `IOCG_GEAR_ONE;
            end
        end
    endfunction

    function [3:0] wordBits;
        input [2:0] g;
        begin
            case (g)
                `IOCG_GEAR_TWO:   wordBits = `IOCG_BITS_TWO;
                `IOCG_GEAR_FOUR:  wordBits = `IOCG_BITS_FOUR;
                `IOCG_GEAR_FIVE:  wordBits = `IOCG_BITS_FIVE;
                `IOCG_GEAR_SEVEN: wordBits = `IOCG_BITS_SEVEN;
                default:          wordBits = `IOCG_BITS_ONE;
            endcase
        end
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    reg                      rstMeta;
    reg                      rstn;
    wire [`IOCG_SYNC_W-1:0]  syncIn;
    wire [`IOCG_SYNC_W-1:0]  s;
    reg  [`IOCG_SYNC_W-1:0]  prev;
    wire                     fastEv;
    wire                     sysRise;
    wire                     strobeEv;
    wire                     wsEv;
    wire                     wdqEv;
    wire                     dataEv;
    wire [2:0]               gear;
    wire [3:0]               nBits;
    wire                     fifoValid;
    wire [`IOCG_FIFO_W-1:0]  fifoData;
    wire                     fifoPush;
    wire                     inBit;
    wire                     inTake;
    wire [9:0]               nextShift;
    reg  [9:0]               shiftReg;
    reg  [3:0]               bitCnt;
    reg  [9:0]               updateWord;
    reg                      updateFull;
    reg                      alignPrev;
    reg                      alignPend;
    wire                     wordDone;
    wire                     outGeared;
    wire                     outEv;
    reg  [9:0]               outShift;
    reg  [3:0]               outCnt;
    reg  [1:0]               oeHold;
    reg                      oePhase;
    reg  [7:0]               sinceEdge;
    reg  [7:0]               transAt;

    // ****************************************
    // Reset release and input sampling
    // ****************************************
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstn    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstn    <= rstMeta;
        end
    end

    assign syncIn = {writeDataClockQ, writeStrobeClock, strobeClock,
                     serialIn, sysClock, fastEdgeClock};

    iocg_sync #(
        .WIDTH (`IOCG_SYNC_W)
    ) iocg_sync_i (
        .clk  (clk),
        .rstn (rstn),
        .din  (syncIn),
        .dout (s)
    );

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev <= {`IOCG_SYNC_W{1'b0}};
        end else begin
            prev <= s;
        end
    end

    assign fastEv   = s[0] ^ prev[0];
    assign sysRise  = s[1] & ~prev[1];
    assign dataEv   = s[2] ^ prev[2];
    assign strobeEv = s[3] ^ prev[3];
    assign wsEv     = s[4] ^ prev[4];
    assign wdqEv    = s[5] ^ prev[5];

    assign gear  = gearSel(gearMode, ioCellPairLinked);
    assign nBits = wordBits(gear);

    // ****************************************
    // Input FIFO
    // ****************************************
    // Write on strobe edges
    assign fifoPush = (BOTTOM_EDGE != 0) && memReadMode && strobeEv;

    iocg_fifo #(
        .WIDTH (`IOCG_FIFO_W),
        .DEPTH (`IOCG_FIFO_DEPTH),
        .AW    (`IOCG_FIFO_AW)
    ) iocg_fifo_i (
        .clk          (clk),
        .rstn         (rstn),
        .clear        (inputBlockReset),
        .inValid      (fifoPush),
        .inReady      (fifoInReady),
        .inData       (s[2]),
        .outValid     (fifoValid),
        .outReady     (fastEv & memReadMode),
        .outData      (fifoData),
        .writePointer (fifoWritePointer),
        .readPointer  (fifoReadPointer)
    );

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fifoOverflow <= 1'b0;
        end else if (fifoPush && !fifoInReady) begin
            fifoOverflow <= 1'b1;
        end else if (inputBlockReset) begin
            fifoOverflow <= 1'b0;
        end
    end

    assign inBit  = memReadMode ? fifoData[0] : s[2];
    assign inTake = memReadMode ? (fastEv & fifoValid) : fastEv;

    // ****************************************
    // Input stages one and two
    // ****************************************
    assign nextShift = {inBit, shiftReg[9:1]};
    assign wordDone  = inTake && !alignPend && (bitCnt == nBits - 4'h1);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shiftReg   <= 10'h000;
            bitCnt     <= 4'h0;
            updateWord <= 10'h000;
            alignPrev  <= 1'b0;
            alignPend  <= 1'b0;
        end else if (inputBlockReset) begin
            shiftReg   <= 10'h000;
            bitCnt     <= 4'h0;
            updateWord <= 10'h000;
            alignPrev  <= 1'b0;
            alignPend  <= 1'b0;
        end else begin
            alignPrev <= wordAlignRequest;
            if (wordAlignRequest && !alignPrev) begin
                alignPend <= 1'b1;
            end else if (inTake) begin
                alignPend <= 1'b0;
            end
            if (inTake) begin
                shiftReg <= nextShift;
                if (wordDone) begin
                    bitCnt <= 4'h0;
                    updateWord <= nextShift >> (`IOCG_WORD_MAX - nBits);
                end else if (!alignPend) begin
                    bitCnt <= bitCnt + 4'h1;
                end
            end
        end
    end

    // ****************************************
    // Input stage three
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            updateFull   <= 1'b0;
            parWordOut   <= 10'h000;
            parWordValid <= 1'b0;
        end else if (inputBlockReset) begin
            updateFull   <= 1'b0;
            parWordOut   <= 10'h000;
            parWordValid <= 1'b0;
        end else begin
            parWordValid <= 1'b0;
            if (sysRise && updateFull) begin
                parWordOut   <= updateWord;
                parWordValid <= 1'b1;
            end
            if (inTake && wordDone) begin
                updateFull <= 1'b1;
            end else if (sysRise) begin
                updateFull <= 1'b0;
            end
        end
    end

    // ****************************************
    // Output path
    // ****************************************
    // Single rate off bottom
    assign outGeared = (BOTTOM_EDGE != 0) && !sdrOutMode;
    assign outEv     = memWriteMode ? wdqEv : fastEv;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outShift  <= 10'h000;
            outCnt    <= 4'h0;
            serialOut <= 1'b0;
            strobeOut <= 1'b0;
        end else if (outputBlockReset) begin
            outShift  <= 10'h000;
            outCnt    <= 4'h0;
            serialOut <= 1'b0;
            strobeOut <= 1'b0;
        end else if (!outGeared) begin
            if (sysRise) begin
                serialOut <= sdrDataIn;
            end
        end else begin
            if (sysRise) begin
                outShift <= parWordIn;
                outCnt   <= nBits;
            end else if (outEv && outCnt != 4'h0) begin
                serialOut <= outShift[0];
                outShift  <= {1'b0, outShift[9:1]};
                outCnt    <= outCnt - 4'h1;
            end
            if (wsEv) begin
                strobeOut <= memWriteMode && (outCnt != 4'h0) && s[4];
            end
        end
    end

    // ****************************************
    // Tristate path
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            outputEnableOut <= 1'b0;
            oeHold          <= 2'h0;
            oePhase         <= 1'b0;
        end else if (tristateBlockReset) begin
            outputEnableOut <= 1'b0;
            oeHold          <= 2'h0;
            oePhase         <= 1'b0;
        end else if (BOTTOM_EDGE != 0 && tristateDdrGear) begin
            if (sysRise) begin
                oeHold  <= outputEnableInDdr;
                oePhase <= 1'b0;
            end else if (fastEv) begin
                outputEnableOut <= oeHold[oePhase];
                oePhase         <= ~oePhase;
            end
        end else if (sysRise) begin
            outputEnableOut <= outputEnableIn;
        end
    end

    // ****************************************
    // Edge monitor
    // ****************************************
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sinceEdge <= 8'h00;
            transAt   <= 8'h00;
            eyeCentre <= 8'h00;
        end else if (BOTTOM_EDGE != 0) begin
            // Eye centre half a bit after data edge
            if (fastEv) begin
                sinceEdge <= 8'h00;
                eyeCentre <= transAt + {1'b0, sinceEdge[7:1]};
            end else if (sinceEdge != 8'hff) begin
                sinceEdge <= sinceEdge + 8'h01;
            end
            if (dataEv) begin
                transAt <= sinceEdge;
            end
        end
    end
endmodule // iocg_io_cell

// ===== verif/iocg_io_cell_checker.sv
// Port assertions for the I/O cell gearing paths.
// Assumes it is bound onto iocg_io_cell with the defines in reach.
`timescale 1ns/1ps
`include "iocg_defines.vh"
module iocg_io_cell_checker (
    input wire       clk,
    input wire       resetn,
    input wire [2:0] gearMode,
    input wire       ioCellPairLinked,
    input wire       inputBlockReset,
    input wire       tristateBlockReset,
    input wire       tristateDdrGear,
    input wire       outputEnableIn,
    input wire       memWriteMode,
    input wire [9:0] parWordOut,
    input wire       parWordValid,
    input wire [2:0] fifoReadPointer,
    input wire [2:0] fifoWritePointer,
    input wire       fifoInReady,
    input wire       fifoOverflow,
    input wire       strobeOut,
    input wire       outputEnableOut
);
    // ****************************************
    // Assertions
    // ****************************************
    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);
    function automatic [3:0] bitsOf(input [2:0] m, input p);
        case (m)
            `IOCG_GEAR_TWO:   bitsOf = `IOCG_BITS_TWO;
            `IOCG_GEAR_FOUR:  bitsOf = `IOCG_BITS_FOUR;
            `IOCG_GEAR_FIVE:  bitsOf = `IOCG_BITS_FIVE;
            `IOCG_GEAR_SEVEN: bitsOf = p ? `IOCG_BITS_SEVEN : `IOCG_BITS_ONE;
            default:          bitsOf = `IOCG_BITS_ONE;
        endcase
    endfunction
    property p_valid_pulse; parWordValid |=> !parWordValid; endproperty
    a_valid_pulse: assert property (p_valid_pulse)
        else $error("word valid longer than one cycle");
    property p_word_width;
        parWordValid |->
            (parWordOut >> bitsOf(gearMode, ioCellPairLinked)) == 10'h000;
    endproperty
    a_word_width: assert property (p_word_width)
        else $error("word wider than gear");
    property p_word_stands;
        $changed(parWordOut) && !$past(inputBlockReset) |->
            ##[0:1] parWordValid;
    endproperty
    a_word_stands: assert property (p_word_stands)
        else $error("word changed without transfer");
    property p_ovf_sticky; fifoOverflow && !inputBlockReset |=> fifoOverflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag dropped");
    property p_ovf_cause;
        $rose(fifoOverflow) |-> !$past(fifoInReady);
    endproperty
    a_ovf_cause: assert property (p_ovf_cause)
        else $error("overflow while not full");
    property p_wptr_step;
        $changed(fifoWritePointer) && !$past(inputBlockReset) |->
            fifoWritePointer == $past(fifoWritePointer) + 3'h1;
    endproperty
    a_wptr_step: assert property (p_wptr_step)
        else $error("write pointer jumped");
    property p_rptr_step;
        $changed(fifoReadPointer) && !$past(inputBlockReset) |->
            fifoReadPointer == $past(fifoReadPointer) + 3'h1;
    endproperty
    a_rptr_step: assert property (p_rptr_step)
        else $error("read pointer jumped");
    property p_full_equal;
        !fifoInReady |-> fifoWritePointer == fifoReadPointer;
    endproperty
    a_full_equal: assert property (p_full_equal)
        else $error("full with unequal pointers");
    property p_sdr_enable;
        !tristateDdrGear && !$past(tristateDdrGear) &&
            $changed(outputEnableOut) && !$past(tristateBlockReset) |->
            outputEnableOut == $past(outputEnableIn);
    endproperty
    a_sdr_enable: assert property (p_sdr_enable)
        else $error("enable not from its input");
    property p_tri_clear; tristateBlockReset |=> !outputEnableOut; endproperty
    a_tri_clear: assert property (p_tri_clear)
        else $error("enable survived its reset");
    property p_strobe_mode;
        $rose(strobeOut) |-> $past(memWriteMode);
    endproperty
    a_strobe_mode: assert property (p_strobe_mode)
        else $error("strobe outside write mode");
    c_five: cover property (parWordValid && gearMode == `IOCG_GEAR_FIVE);
    c_ovf: cover property ($rose(fifoOverflow));
    c_strobe: cover property ($rose(strobeOut));
endmodule // iocg_io_cell_checker
bind iocg_io_cell iocg_io_cell_checker iocg_io_cell_checker_i (
    .clk(clk), .resetn(resetn), .gearMode(gearMode),
    .ioCellPairLinked(ioCellPairLinked), .inputBlockReset(inputBlockReset),
    .tristateBlockReset(tristateBlockReset), .tristateDdrGear(tristateDdrGear),
    .outputEnableIn(outputEnableIn), .memWriteMode(memWriteMode),
    .parWordOut(parWordOut), .parWordValid(parWordValid),
    .fifoReadPointer(fifoReadPointer), .fifoWritePointer(fifoWritePointer),
    .fifoInReady(fifoInReady), .fifoOverflow(fifoOverflow),
    .strobeOut(strobeOut), .outputEnableOut(outputEnableOut)
);

// ===== verif/iocg_link_model.sv
// Far-side link source and sink for one I/O cell.
// Assumes clk is the cell clock; link edges every 4 clk (320 ns period).
`timescale 1ns/1ps
module iocg_link_model (
    input  wire       clk,
    input  wire       serialOut,
    input  wire       outputEnableOut,
    input  wire       strobeOut,
    output reg        fastEdgeClock,
    output reg        sysClock,
    output reg        serialIn,
    output reg        strobeClock,
    output reg        writeStrobeClock,
    output reg        writeDataClockQ
);
    reg [9:0] capOut;
    reg [9:0] capEn;
    reg [9:0] capStb;
    initial begin
        {fastEdgeClock, sysClock, serialIn} = 3'h0;
        {strobeClock, writeStrobeClock, writeDataClockQ} = 3'h0;
    end
    // ****************************************
    // Link tasks
    // ****************************************
    // Bit per edge, strobe leads
    task edges(input [9:0] w, input integer n, input wr);
        integer i;
        for (i = 0; i <= n; i = i + 1) begin
            @(posedge clk);
            #1;
            if (i > 0) begin
                capOut[i-1] = serialOut;
                capEn[i-1] = outputEnableOut;
                capStb[i-1] = strobeOut;
            end
            if (i < n) begin
                serialIn = w[i];
                if (wr) writeStrobeClock = ~writeStrobeClock;
                @(posedge clk);
                #1;
                if (wr) writeDataClockQ = ~writeDataClockQ;
                else fastEdgeClock = ~fastEdgeClock;
                repeat (2) @(posedge clk);
            end
        end
        serialIn = ~serialIn;
    endtask
    task fill(input [9:0] w, input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge clk);
            #1 serialIn = w[i];
            @(posedge clk);
            #1 strobeClock = ~strobeClock;
            repeat (2) @(posedge clk);
        end
        #1 serialIn = ~serialIn;
    endtask
    task sysRise;
        @(posedge clk);
        #1 sysClock = 1'b1;
        repeat (4) @(posedge clk);
        #1 sysClock = 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
endmodule // iocg_link_model

// ===== verif/iocg_io_cell_test.sv
// Self-checking bench for the I/O cell gearing paths.
// Assumes the link model and the bound port checker.
`timescale 1ns/1ps
`include "iocg_defines.vh"
module iocg_io_cell_test;
    reg        clk, resetn, inputBlockReset, outputBlockReset;
    reg        tristateBlockReset, memReadMode, memWriteMode, sdrOutMode;
    reg        ioCellPairLinked, wordAlignRequest, sdrDataIn;
    reg        outputEnableIn, tristateDdrGear;
    reg  [2:0] gearMode;
    reg  [9:0] parWordIn;
    reg  [1:0] outputEnableInDdr;
    wire       fastEdgeClock, sysClock, serialIn, strobeClock;
    wire       writeStrobeClock, writeDataClockQ, parWordValid;
    wire       fifoInReady, fifoOverflow, serialOut, strobeOut;
    wire       outputEnableOut;
    wire [9:0] parWordOut;
    wire [2:0] fifoReadPointer, fifoWritePointer;
    wire [7:0] eyeCentre;
    integer    errTotal, checksDone, cycles;
    iocg_io_cell iocg_io_cell_i (.*);
    iocg_link_model iocg_link_model_i (.*);
    // ****************************************
    // Helpers
    // ****************************************
    task step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        checksDone = checksDone + 1;
        if (got !== exp) begin
            errTotal = errTotal + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task reportAndStop;
        $display("checks %0d errors %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task tGears;
        integer k, n;
        reg [9:0] pat, mask;
        for (k = 0; k < 6; k = k + 1) begin
            gearMode = (k == 5) ? `IOCG_GEAR_SEVEN : k[2:0];
            ioCellPairLinked = (k == 4);
            n = (k == 1) ? 4 : (k == 2) ? 8 : (k == 3) ? 10 :
                (k == 4) ? 7 : 2;
            pat = 10'h2d3 ^ (10'h05b << k);
            mask = (10'h001 << n) - 10'h001;
            parWordIn = pat;
            iocg_link_model_i.sysRise;
            iocg_link_model_i.edges(pat, n, 1'b0);
            iocg_link_model_i.sysRise;
            chk(parWordOut, pat & mask);
            chk(iocg_link_model_i.capOut & mask, pat & mask);
        end
    endtask
    task tAlign;
        gearMode = `IOCG_GEAR_TWO;
        wordAlignRequest = 1'b1;
        iocg_link_model_i.edges(10'h015, 5, 1'b0);
        wordAlignRequest = 1'b0;
        iocg_link_model_i.sysRise;
        chk(parWordOut, 10'h00a);
        chk(eyeCentre, 8'h03);
    endtask
    task tFifo;
        gearMode = `IOCG_GEAR_ONE;
        memReadMode = 1'b1;
        iocg_link_model_i.fill(10'h0a9, 8);
        step(3);
        chk(fifoInReady, 1'b0);
        iocg_link_model_i.fill(10'h000, 1);
        step(3);
        chk(fifoOverflow, 1'b1);
        iocg_link_model_i.edges(10'h3ff, 2, 1'b0);
        iocg_link_model_i.sysRise;
        chk(parWordOut, 10'h001);
        chk({fifoInReady, fifoReadPointer, fifoWritePointer}, 7'h50);
        inputBlockReset = 1'b1;
        step(1);
        inputBlockReset = 1'b0;
        step(1);
        chk({fifoOverflow, fifoInReady}, 2'h1);
        memReadMode = 1'b0;
    endtask
    task tTri;
        outputEnableIn = 1'b1;
        iocg_link_model_i.sysRise;
        chk(outputEnableOut, 1'b1);
        tristateBlockReset = 1'b1;
        step(1);
        tristateBlockReset = 1'b0;
        step(1);
        chk(outputEnableOut, 1'b0);
        tristateDdrGear = 1'b1;
        outputEnableInDdr = 2'h1;
        iocg_link_model_i.sysRise;
        iocg_link_model_i.edges(10'h000, 3, 1'b0);
        chk(iocg_link_model_i.capEn[2:0], 3'h5);
        tristateDdrGear = 1'b0;
        outputEnableIn = 1'b0;
        iocg_link_model_i.sysRise;
        chk(outputEnableOut, 1'b0);
    endtask
    task tMemWr;
        gearMode = `IOCG_GEAR_TWO;
        memWriteMode = 1'b1;
        parWordIn = 10'h00b;
        iocg_link_model_i.sysRise;
        iocg_link_model_i.edges(10'h000, 4, 1'b1);
        chk({iocg_link_model_i.capStb[0], iocg_link_model_i.capOut[3:0]},
            5'h1b);
        memWriteMode = 1'b0;
    endtask
    task tSdr;
        sdrOutMode = 1'b1;
        sdrDataIn = 1'b0;
        iocg_link_model_i.sysRise;
        chk(serialOut, 1'b0);
        sdrDataIn = 1'b1;
        iocg_link_model_i.sysRise;
        chk(serialOut, 1'b1);
        outputBlockReset = 1'b1;
        step(1);
        outputBlockReset = 1'b0;
        step(1);
        chk(serialOut, 1'b0);
        sdrOutMode = 1'b0;
        sdrDataIn = 1'b0;
    endtask
    // ****************************************
    // Clock, reset, sequence, timeout
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {resetn, inputBlockReset, outputBlockReset, tristateBlockReset} = 4'h0;
        {memReadMode, memWriteMode, sdrOutMode, ioCellPairLinked} = 4'h0;
        {wordAlignRequest, sdrDataIn, outputEnableIn, tristateDdrGear} = 4'h0;
        {gearMode, parWordIn, outputEnableInDdr} = 15'h0000;
        {errTotal, checksDone, cycles} = 96'h0;
        repeat (6) @(posedge clk);
        #1 resetn = 1'b1;
        step(6);
        tGears;
        tAlign;
        tFifo;
        tTri;
        tMemWr;
        tSdr;
        reportAndStop;
    end
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            errTotal = errTotal + 1;
            reportAndStop;
        end
    end
endmodule // iocg_io_cell_test
